/* File: common/dtc_map.svh */
// Purpose: address map, bit positions and counts of the dual timer/counter
// Assumes: byte wide special function register port of the core
// Notes: definitions only
// Behaviour
// R1: timer one gating bit 7 set: count only while gate pin high and run set
// R2: timer zero gating bit 3 set: count only while gate pin high and run set
// R3: timer one select bit 6: one counts count pin falls, zero counts machine cycles
// R4: timer zero select bit 2: one counts count pin falls, zero counts machine cycles
// R5: timer zero mode field in bits 1:0, timer one mode field in bits 5:4
// R6: mode 10 counts low byte, reloads it from high byte on overflow
// R7: control register bits 7..4 hold flag1, run1, flag0, run0; low nibble external
// R8: mode 00 is a 13-bit count of high byte and low five bits
// R9: overflow sets the flag; interrupt vectoring clears it
// R10: mode 11 stops timer one; timer zero splits, high byte uses run1/flag1
// R11: timer mode counts once per 12-clock machine cycle; run does not clear count
// R12: mode 01 is a cascaded 16-bit count, flag set on rollover to zero
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH
`define DTC_ADDR_CONTROL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_T0_LO 8'h8A
`define DTC_ADDR_T1_LO 8'h8B
`define DTC_ADDR_T0_HI 8'h8C
`define DTC_ADDR_T1_HI 8'h8D
`define DTC_RESET_BYTE 8'h00
`define DTC_MC_LAST 4'hB
`define DTC_MC_FIRST 4'h0
`define DTC_M_GATE1 7
`define DTC_M_SEL1 6
`define DTC_M_MODE1_HI 5
`define DTC_M_MODE1_LO 4
`define DTC_M_GATE0 3
`define DTC_M_SEL0 2
`define DTC_M_MODE0_HI 1
`define DTC_M_MODE0_LO 0
`define DTC_C_FLAG1 7
`define DTC_C_RUN1 6
`define DTC_C_FLAG0 5
`define DTC_C_RUN0 4
`define DTC_LOW13_TOP 4
`endif

/* File: common/dtc_pkg.sv */
// Purpose: types of the dual timer/counter
// Assumes: nothing
// Notes: mode codes follow the mode field
`default_nettype none
package dtc_pkg;
   typedef enum logic [1:0] {
      DTC_MODE_13BIT = 2'h0,
      DTC_MODE_16BIT = 2'h1,
      DTC_MODE_RELOAD = 2'h2,
      DTC_MODE_SPLIT = 2'h3
   } dtc_mode_type;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dtc_sfr_req_type;
   typedef struct packed {
      logic ext_gate_pin0;
      logic ext_gate_pin1;
      logic count_pin0;
      logic count_pin1;
   } dtc_pins_type;
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
      logic ovf;
   } dtc_step_type;
   typedef struct packed {
      logic [3:0] mc_count;
      logic [7:0] timer_mode_config;
      logic [7:0] timer_control;
      logic [7:0] timer0_low_byte;
      logic [7:0] timer0_high_byte;
      logic [7:0] timer1_low_byte;
      logic [7:0] timer1_high_byte;
      logic samp0;
      logic samp1;
      logic [7:0] rdata;
   } dtc_state_type;
endpackage
`default_nettype wire

/* File: rtl/dtc_timer.sv */
// Purpose: mode and control logic of timer/counters zero and one
// Assumes: pins synchronous to ref_clk; read data one cycle after sfr rd
// Notes: software writes to count bytes win over a same-cycle increment
`include "dtc_map.svh"
`default_nettype none
module dtc_timer import dtc_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst,
   input wire dtc_sfr_req_type sfr_req,
   output logic [7:0] sfr_rdata,
   input wire dtc_pins_type pins,
   input wire logic irq_ack0,
   input wire logic irq_ack1,
   output logic timer0_overflow_flag,
   output logic timer1_overflow_flag
);
   dtc_state_type s_q;
   dtc_state_type s_d;

   // one counting step for a timer in the given mode
   function automatic dtc_step_type step(input logic [1:0] mode, input logic [7:0] hi,
                                         input logic [7:0] lo, input logic inc);
      dtc_step_type r;
      logic [13:0] c13;
      logic [16:0] c16;
      logic [8:0] c8;
      r.hi = hi;
      r.lo = lo;
      r.ovf = 1'b0;
      c13 = {1'b0, hi, lo[`DTC_LOW13_TOP:0]} + 14'h0001;
      c16 = {1'b0, hi, lo} + 17'h00001;
      c8 = {1'b0, lo} + 9'h001;
      if (inc) begin
         case (dtc_mode_type'(mode))
            DTC_MODE_13BIT: begin
               r.hi = c13[12:5]; // [R8]
               r.lo = {lo[7:5], c13[4:0]}; // [R8]
               r.ovf = c13[13];
            end
            DTC_MODE_16BIT: begin
               r.hi = c16[15:8]; // [R12]
               r.lo = c16[7:0];
               r.ovf = c16[16]; // [R12]
            end
            DTC_MODE_RELOAD: begin
               r.lo = c8[8] ? hi : c8[7:0]; // [R6]
               r.ovf = c8[8];
            end
            default: begin
               r.lo = c8[7:0];
               r.ovf = c8[8];
            end
         endcase
      end
      return r;
   endfunction

   logic tick;
   logic fall0;
   logic fall1;
   logic run0;
   logic run1;
   logic inc0;
   logic inc1;
   logic split0;
   logic [1:0] mode0;
   logic [1:0] mode1;
   logic [8:0] hi0_split;
   dtc_step_type st0;
   dtc_step_type st1;

   always_comb begin
      s_d = s_q;
      tick = (s_q.mc_count == `DTC_MC_LAST); // [R11]
      s_d.mc_count = tick ? `DTC_MC_FIRST : s_q.mc_count + 4'h1; // [R11]
      mode0 = {s_q.timer_mode_config[`DTC_M_MODE0_HI],
               s_q.timer_mode_config[`DTC_M_MODE0_LO]}; // [R5]
      mode1 = {s_q.timer_mode_config[`DTC_M_MODE1_HI],
               s_q.timer_mode_config[`DTC_M_MODE1_LO]}; // [R5]
      split0 = (dtc_mode_type'(mode0) == DTC_MODE_SPLIT);
      // count pins sampled once per machine cycle, falling edge between samples
      fall0 = tick & s_q.samp0 & ~pins.count_pin0;
      fall1 = tick & s_q.samp1 & ~pins.count_pin1;
      if (tick) begin
         s_d.samp0 = pins.count_pin0;
         s_d.samp1 = pins.count_pin1;
      end
      run0 = s_q.timer_control[`DTC_C_RUN0] &
             (~s_q.timer_mode_config[`DTC_M_GATE0] | pins.ext_gate_pin0); // [R2]
      run1 = s_q.timer_control[`DTC_C_RUN1] &
             (~s_q.timer_mode_config[`DTC_M_GATE1] | pins.ext_gate_pin1); // [R1]
      inc0 = run0 & (s_q.timer_mode_config[`DTC_M_SEL0] ? fall0 : tick); // [R4]
      inc1 = run1 & (s_q.timer_mode_config[`DTC_M_SEL1] ? fall1 : tick) &
             (dtc_mode_type'(mode1) != DTC_MODE_SPLIT); // [R3] [R10]
      st0 = step(mode0, s_q.timer0_high_byte, s_q.timer0_low_byte, inc0);
      st1 = step(mode1, s_q.timer1_high_byte, s_q.timer1_low_byte, inc1);
      // split mode: high byte of timer zero counts machine cycles on run1
      hi0_split = {1'b0, s_q.timer0_high_byte} +
                  {8'h00, tick & s_q.timer_control[`DTC_C_RUN1]}; // [R10]
      s_d.timer0_low_byte = st0.lo;
      s_d.timer0_high_byte = split0 ? hi0_split[7:0] : st0.hi;
      s_d.timer1_low_byte = st1.lo;
      s_d.timer1_high_byte = st1.hi;
      // software access
      if (sfr_req.wr) begin
         case (sfr_req.addr)
            `DTC_ADDR_CONTROL: s_d.timer_control = sfr_req.wdata; // [R7]
            `DTC_ADDR_MODE: s_d.timer_mode_config = sfr_req.wdata;
            `DTC_ADDR_T0_LO: s_d.timer0_low_byte = sfr_req.wdata;
            `DTC_ADDR_T0_HI: s_d.timer0_high_byte = sfr_req.wdata;
            `DTC_ADDR_T1_LO: s_d.timer1_low_byte = sfr_req.wdata;
            `DTC_ADDR_T1_HI: s_d.timer1_high_byte = sfr_req.wdata;
            default: ;
         endcase
      end
      // vectoring clears a flag; a same-cycle overflow still sets it
      if (irq_ack0) begin
         s_d.timer_control[`DTC_C_FLAG0] = 1'b0; // [R9]
      end
      if (irq_ack1) begin
         s_d.timer_control[`DTC_C_FLAG1] = 1'b0; // [R9]
      end
      if (st0.ovf) begin
         s_d.timer_control[`DTC_C_FLAG0] = 1'b1; // [R9]
      end
      if ((split0 & hi0_split[8]) | (~split0 & st1.ovf)) begin
         s_d.timer_control[`DTC_C_FLAG1] = 1'b1; // [R9] [R10]
      end
      if (sfr_req.rd) begin
         case (sfr_req.addr)
            `DTC_ADDR_CONTROL: s_d.rdata = s_q.timer_control; // [R7]
            `DTC_ADDR_MODE: s_d.rdata = s_q.timer_mode_config;
            `DTC_ADDR_T0_LO: s_d.rdata = s_q.timer0_low_byte;
            `DTC_ADDR_T0_HI: s_d.rdata = s_q.timer0_high_byte;
            `DTC_ADDR_T1_LO: s_d.rdata = s_q.timer1_low_byte;
            `DTC_ADDR_T1_HI: s_d.rdata = s_q.timer1_high_byte;
            default: s_d.rdata = `DTC_RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sfr_rdata = s_q.rdata;
   assign timer0_overflow_flag = s_q.timer_control[`DTC_C_FLAG0];
   assign timer1_overflow_flag = s_q.timer_control[`DTC_C_FLAG1];
endmodule
`default_nettype wire

/* File: testbench/dtc_timer_checker.sv */
// Purpose: port assertions of the dual timer/counter
// Assumes: read data one cycle after rd
// Notes: bound to dtc_timer
`default_nettype none
module dtc_checker import dtc_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst,
   input wire dtc_sfr_req_type sfr_req,
   input wire logic [7:0] sfr_rdata,
   input wire logic irq_ack0,
   input wire logic irq_ack1,
   input wire logic timer0_overflow_flag,
   input wire logic timer1_overflow_flag
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_unmapped_read_zero: assert property (
      sfr_req.rd && sfr_req.addr > 8'h8D |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_read_data_holds: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
      else $error("read data moved");
   a_ctrl_read_flags: assert property (sfr_req.rd && sfr_req.addr == 8'h88 |=>
      sfr_rdata[7] == $past(timer1_overflow_flag) && sfr_rdata[5] == $past(timer0_overflow_flag))
      else $error("control read flags wrong");
   a_flag0_stands: assert property (timer0_overflow_flag && !irq_ack0 &&
      !(sfr_req.wr && sfr_req.addr == 8'h88) |=> timer0_overflow_flag) else $error("flag0 lost");
   a_flag1_stands: assert property (timer1_overflow_flag && !irq_ack1 &&
      !(sfr_req.wr && sfr_req.addr == 8'h88) |=> timer1_overflow_flag) else $error("flag1 lost");
   a_sw_sets_flag0: assert property (
      sfr_req.wr && sfr_req.addr == 8'h88 && sfr_req.wdata[5] |=> timer0_overflow_flag)
      else $error("flag0 not written");
   a_sw_sets_flag1: assert property (
      sfr_req.wr && sfr_req.addr == 8'h88 && sfr_req.wdata[7] |=> timer1_overflow_flag)
      else $error("flag1 not written");
   a_reset_clears_flags: assert property (
      $fell(rst) |-> !timer0_overflow_flag && !timer1_overflow_flag)
      else $error("flags set after reset");
endmodule
bind dtc_timer dtc_checker chk (.ref_clk(ref_clk), .rst(rst), .sfr_req(sfr_req),
   .sfr_rdata(sfr_rdata), .irq_ack0(irq_ack0), .irq_ack1(irq_ack1),
   .timer0_overflow_flag(timer0_overflow_flag), .timer1_overflow_flag(timer1_overflow_flag));
`default_nettype wire

/* File: testbench/test_dtc_timer.sv */
// Purpose: self-checking bench of the dual timer/counter
// Assumes: inputs change 1 ns after the rising edge
// Notes: xorshift stimulus seeded with 72
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module test_dtc_timer import dtc_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 0, rst = 1, irq_ack0 = 0, irq_ack1 = 0, f0, f1;
   dtc_sfr_req_type req = '0;
   dtc_pins_type pins = '0;
   logic [7:0] rdata, v, r;
   logic [31:0] seed = 32'h48;
   int err_total = 0, tests_run = 0, n;
   always #2 ref_clk = ~ref_clk;
   dtc_timer uut (.ref_clk(ref_clk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata), .pins(pins),
      .irq_ack0(irq_ack0), .irq_ack1(irq_ack1), .timer0_overflow_flag(f0),
      .timer1_overflow_flag(f1));
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic step(int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   // kept bits of the low byte in 13-bit mode
   function automatic logic [7:0] m0_low(logic [7:0] x);
      return x & 8'hE0;
   endfunction
   // strobe released, then one idle edge so the next call starts clean
   task automatic wr(logic [7:0] a, logic [7:0] d);
      req = '{a, d, 1'b1, 1'b0};
      step(1);
      req = '0;
      step(1);
   endtask
   task automatic rd(logic [7:0] a, output logic [7:0] d);
      req = '{a, 8'h00, 1'b0, 1'b1};
      step(1);
      d = rdata;
      req = '0;
      step(1);
   endtask
   task automatic wflag(bit one, output int c);
      c = 0;
      while ((one ? f1 : f0) !== 1'b1 && c < 400) begin
         step(1);
         c++;
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      step(5000);
      err_total++;
      wrap_up();
   end
   initial begin
      step(10);
      rst = 0;
      for (int a = 8'h88; a < 8'h8F; a++) begin
         rd(a[7:0], v);
         `CHK(v, 8'h00)
      end
      r = rnd();
      wr(8'h89, r);
      rd(8'h89, v);
      `CHK(v, r)
      wr(8'h89, 8'h01);
      wr(8'h8C, 8'hFF);
      wr(8'h8A, 8'hFE);
      wr(8'h88, 8'h10);
      wflag(0, n);
      `CHK(n > 11 && n < 24, 1'b1)
      wr(8'h88, 8'h20);
      rd(8'h8C, v);
      `CHK(v, 8'h00)
      irq_ack0 = 1;
      step(1);
      irq_ack0 = 0;
      `CHK(f0, 1'b0)
      wr(8'h89, 8'h00);
      r = rnd() | 8'h1F;
      wr(8'h8C, 8'hFF);
      wr(8'h8A, r);
      wr(8'h88, 8'h10);
      wflag(0, n);
      `CHK(n < 13, 1'b1)
      wr(8'h88, 8'h00);
      rd(8'h8A, v);
      `CHK(v, m0_low(r))
      r = rnd();
      wr(8'h89, 8'h20);
      wr(8'h8D, r);
      wr(8'h8B, 8'hFF);
      wr(8'h88, 8'h40);
      wflag(1, n);
      `CHK(n < 12, 1'b1)
      wr(8'h88, 8'h80);
      rd(8'h8B, v);
      `CHK(v, r)
      irq_ack1 = 1;
      step(1);
      irq_ack1 = 0;
      `CHK(f1, 1'b0)
      for (int u = 0; u < 2; u++) begin
         wr(8'h89, u ? 8'hD0 : 8'h0D);
         wr(u ? 8'h8B : 8'h8A, 8'h00);
         wr(8'h88, u ? 8'h40 : 8'h10);
         for (int g = 0; g < 2; g++) begin
            repeat (3) begin
               pins = '{g[0], g[0], 1'b1, 1'b1};
               step(24);
               pins = '{g[0], g[0], 1'b0, 1'b0};
               step(24);
            end
            rd(u ? 8'h8B : 8'h8A, v);
            `CHK(v, g ? 8'h03 : 8'h00)
         end
         wr(8'h88, 8'h00);
      end
      // split mode: high byte of timer zero runs on run1 and raises flag1
      wr(8'h89, 8'h03);
      wr(8'h8C, 8'hFF);
      wr(8'h8A, 8'h00);
      wr(8'h88, 8'h40);
      wflag(1, n);
      `CHK(n < 12, 1'b1)
      `CHK(f0, 1'b0)
      wr(8'h88, 8'h00);
      rd(8'h8A, v);
      `CHK(v, 8'h00)
      rd(8'h8C, v);
      `CHK(v, 8'h00)
      // timer one in mode 11 holds its count with run1 set
      rd(8'h8B, r);
      wr(8'h89, 8'h30);
      wr(8'h88, 8'h40);
      step(30);
      rd(8'h8B, v);
      `CHK(v, r)
      `CHK(f1, 1'b0)
      wr(8'h88, 8'h00);
      wrap_up();
   end
endmodule
`default_nettype wire
